// ### thc_pkg.sv
/*
 * thc_pkg: register map, field layout, init values and timing constants
 * of the target hit counter and self-test control block.
 * Assumes the clock runs at 100 MHz.
 */
package thc_pkg;
	// register addresses on the chip register port
	localparam logic [6:0] ADDR_DET_CFG = 7'h0B;
	localparam logic [6:0] ADDR_BITE_CFG = 7'h0C;

	// reset and init values
	localparam logic [15:0] DET_CFG_RESET = 16'h8000;
	localparam logic [15:0] DET_CFG_INIT = 16'h001B;
	localparam logic [15:0] BITE_CFG_RESET = 16'h0000;
	localparam logic [15:0] BITE_CFG_INIT = 16'h0000;

	// detector config field positions
	localparam int HIT_SEL_LSB = 0;
	localparam int GONE_SEL_LSB = 2;
	localparam int DIR_HALVE_BIT = 4;
	localparam int DET_FUSE_W = 5;

	// self-test config field positions
	localparam int BITE_EN_BIT = 0;
	localparam int PHASE_LSB = 1;
	localparam int PD_EN_BIT = 4;
	localparam int MUX_EN_BIT = 5;
	localparam int MON_SEL_LSB = 6;
	localparam int BITE_FIELD_W = 8;

	// hit count for code 0; each code doubles it (10, 20, 40, 80)
	localparam logic [6:0] HIT_BASE = 7'h0A;

	// timing: one base tick per millisecond
	localparam int CLK_PERIOD_NS = 10;
	localparam int TICK_NS = 1000000;
	localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;

	// target-gone timeout in ms per code
	localparam logic [7:0] GONE_MS_0 = 8'h0A;
	localparam logic [7:0] GONE_MS_1 = 8'h32;
	localparam logic [7:0] GONE_MS_2 = 8'h64;
	localparam logic [7:0] GONE_MS_3 = 8'hC8;

	// detection hold time in ms per code: 10 ms, 1 s, 10 s, 1 min
	localparam logic [15:0] HOLD_MS_0 = 16'h000A;
	localparam logic [15:0] HOLD_MS_1 = 16'h03E8;
	localparam logic [15:0] HOLD_MS_2 = 16'h2710;
	localparam logic [15:0] HOLD_MS_3 = 16'hEA60;
endpackage

// ### thc_detector.sv
/*
 * thc_detector: digital target detector (hit counter, two direction
 * counters, target-gone timeout, detection hold) and the self-test /
 * monitor control register.
 * Assumes: register port accesses, comparator hits and the init strobe are
 * synchronous single-cycle pulses from the chip's main controller.
 */
// Functional notes
// - detection output goes high when the hit counter reaches 10, 20, 40 or 80 per the hit code.
// - when either direction counter reaches its target both are cleared and the direction pin is written.
// - direction target is the hit count, or half of it when the halve bit is set.
// - if the target-gone time passes with no hit, hit counter and both direction counters clear.
// - target-gone codes 0..3 give 10, 50, 100 and 200 ms.
// - after init an unfused part's detector config reads 0x001B; fused parts load fuse defaults.
// - monitor select routes bandgap, temperature, I common mode or Q common mode to pad four.
// - the monitor mux drives pad four only while its enable bit is 1, default 0.
// - the self-test power detector is on only while its bit is 1; it and self-test enable default off.
// - the self-test phase code selects code times 45 degrees, 0 to 315.
// - detection output drops once the hold time (10 ms, 1 s, 10 s, 1 min) passes since the last reach.
`timescale 1ns/1ps
module thc_detector #(
	parameter int TICK_CYCLES = thc_pkg::TICK_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// chip register port
	input wire logic [6:0] regAddr,
	input wire logic regWrEn,
	input wire logic [15:0] regWrData,
	output logic [15:0] regRdData,
	// init sequence
	input wire logic initLoad,
	input wire logic fuseValid,
	input wire logic [4:0] fuseDetCfg,
	// detector control from other registers
	input wire logic digitalDetectorEnable,
	input wire logic [1:0] detectionHoldTimeSel,
	// comparator
	input wire logic hitPulse,
	input wire logic hitApproaching,
	// detector pins
	output logic targetDetect,
	output logic targetDirection,
	// self-test and monitor controls
	output logic selftestEnable,
	output logic [2:0] selftestPhase,
	output logic selftestPowerDetectorEnable,
	output logic monitorMuxEnable,
	output logic [1:0] monitorSelect
);
	typedef struct packed {
		logic [15:0] detCfg;
		logic [15:0] biteCfg;
		logic [15:0] rdData;
		logic [31:0] tickCnt;
		logic [6:0] hitCnt;
		logic [6:0] dirCntA;
		logic [6:0] dirCntB;
		logic [7:0] goneMs;
		logic goneDone;
		logic [15:0] holdMs;
		logic detect;
		logic direction;
	} thc_state_t;

	thc_state_t s_q;
	thc_state_t s_d;

	// decoded limits
	logic [6:0] hitTarget;
	logic [6:0] dirTarget;
	logic [7:0] goneLimit;
	logic [15:0] holdLimit;
	// per-cycle events and incremented counts
	logic msTick;
	logic hitTaken;
	logic [6:0] hitCntInc;
	logic hitReach;
	logic [6:0] dirCntAInc;
	logic [6:0] dirCntBInc;
	logic dirReach;
	logic [7:0] goneMsInc;
	logic goneExpire;
	logic [15:0] holdMsInc;
	logic holdExpire;
	logic detCfgWrite;
	logic biteCfgWrite;

	// limits follow the stored config; the hold code comes from another register
	always_comb begin
		hitTarget = thc_pkg::HIT_BASE << s_q.detCfg[thc_pkg::HIT_SEL_LSB +: 2];
		dirTarget = s_q.detCfg[thc_pkg::DIR_HALVE_BIT] ? (hitTarget >> 1) : hitTarget;
		unique case (s_q.detCfg[thc_pkg::GONE_SEL_LSB +: 2])
			2'h0: goneLimit = thc_pkg::GONE_MS_0;
			2'h1: goneLimit = thc_pkg::GONE_MS_1;
			2'h2: goneLimit = thc_pkg::GONE_MS_2;
			2'h3: goneLimit = thc_pkg::GONE_MS_3;
		endcase
		unique case (detectionHoldTimeSel)
			2'h0: holdLimit = thc_pkg::HOLD_MS_0;
			2'h1: holdLimit = thc_pkg::HOLD_MS_1;
			2'h2: holdLimit = thc_pkg::HOLD_MS_2;
			2'h3: holdLimit = thc_pkg::HOLD_MS_3;
		endcase
	end

	// the base tick runs free, so the first millisecond of any timer may be short
	always_comb begin
		msTick = (s_q.tickCnt == 32'(TICK_CYCLES - 1));
		hitTaken = digitalDetectorEnable && hitPulse;
		hitCntInc = s_q.hitCnt + 7'h01;
		hitReach = hitCntInc >= hitTarget;
		dirCntAInc = hitApproaching ? s_q.dirCntA + 7'h01 : s_q.dirCntA;
		dirCntBInc = hitApproaching ? s_q.dirCntB : s_q.dirCntB + 7'h01;
		dirReach = dirCntAInc >= dirTarget || dirCntBInc >= dirTarget;
		goneMsInc = s_q.goneMs + 8'h01;
		goneExpire = msTick && !s_q.goneDone && goneMsInc >= goneLimit;
		holdMsInc = s_q.holdMs + 16'h0001;
		holdExpire = s_q.detect && msTick && holdMsInc >= holdLimit;
		detCfgWrite = regWrEn && regAddr == thc_pkg::ADDR_DET_CFG;
		biteCfgWrite = regWrEn && regAddr == thc_pkg::ADDR_BITE_CFG;
	end

	// next state of the whole block
	always_comb begin
		s_d = s_q;
		s_d.tickCnt = msTick ? 32'h0000_0000 : s_q.tickCnt + 32'h0000_0001;

		// register writes; detector config is assumed static while enabled
		if (detCfgWrite) begin
			s_d.detCfg = regWrData;
		end
		if (biteCfgWrite) begin
			s_d.biteCfg = {8'h00, regWrData[thc_pkg::BITE_FIELD_W-1:0]};
		end
		if (initLoad) begin
			s_d.detCfg = thc_pkg::DET_CFG_INIT;
			if (fuseValid) begin
				s_d.detCfg = {11'h000, fuseDetCfg};
			end
			s_d.biteCfg = thc_pkg::BITE_CFG_INIT;
		end
		unique case (regAddr)
			thc_pkg::ADDR_DET_CFG: s_d.rdData = s_q.detCfg;
			thc_pkg::ADDR_BITE_CFG: s_d.rdData = s_q.biteCfg;
			default: s_d.rdData = 16'h0000;
		endcase

		// hold timer runs while detection is high
		// a reach in the same cycle restarts the hold further down
		if (s_q.detect && msTick) begin
			if (holdExpire) begin
				s_d.detect = 1'b0;
				s_d.holdMs = 16'h0000;
			end else begin
				s_d.holdMs = holdMsInc;
			end
		end

		// counters stay cleared while the detector is disabled

		if (!digitalDetectorEnable) begin
			s_d.hitCnt = 7'h00;
			s_d.dirCntA = 7'h00;
			s_d.dirCntB = 7'h00;
			s_d.goneMs = 8'h00;
			s_d.goneDone = 1'b1;
		end else if (hitTaken) begin
			// a hit restarts the target-gone timer and wins over a tick
			s_d.goneMs = 8'h00;
			s_d.goneDone = 1'b0;
			if (hitReach) begin
				s_d.hitCnt = 7'h00;
				s_d.detect = 1'b1;
				s_d.holdMs = 16'h0000;
			end else begin
				s_d.hitCnt = hitCntInc;
			end
			s_d.dirCntA = dirCntAInc;
			s_d.dirCntB = dirCntBInc;
			if (dirReach) begin
				s_d.direction = hitApproaching;
				s_d.dirCntA = 7'h00;
				s_d.dirCntB = 7'h00;
			end
		end else if (msTick && !s_q.goneDone) begin
			if (goneExpire) begin
				s_d.hitCnt = 7'h00;
				s_d.dirCntA = 7'h00;
				s_d.dirCntB = 7'h00;
				s_d.goneMs = 8'h00;
				s_d.goneDone = 1'b1;
			end else begin
				s_d.goneMs = goneMsInc;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_q <= '0;
			s_q.detCfg <= thc_pkg::DET_CFG_RESET;
			s_q.biteCfg <= thc_pkg::BITE_CFG_RESET;
			s_q.goneDone <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign regRdData = s_q.rdData;
	assign targetDetect = s_q.detect;
	assign targetDirection = s_q.direction;
	assign selftestEnable = s_q.biteCfg[thc_pkg::BITE_EN_BIT];
	assign selftestPhase = s_q.biteCfg[thc_pkg::PHASE_LSB +: 3];
	assign selftestPowerDetectorEnable = s_q.biteCfg[thc_pkg::PD_EN_BIT];
	assign monitorMuxEnable = s_q.biteCfg[thc_pkg::MUX_EN_BIT];
	assign monitorSelect = s_q.biteCfg[thc_pkg::MON_SEL_LSB +: 2];
endmodule

// ### thc_sva.sv
/* port checker of thc_detector; bound to every instance, same clock and reset */
`timescale 1ns/1ps
module thc_sva (
	// watched ports
	input wire logic clk,
	input wire logic rst,
	input wire logic [6:0] regAddr,
	input wire logic regWrEn,
	input wire logic [15:0] regWrData,
	input wire logic [15:0] regRdData,
	input wire logic initLoad,
	input wire logic fuseValid,
	input wire logic hitPulse,
	input wire logic targetDetect,
	input wire logic selftestEnable,
	input wire logic [2:0] selftestPhase,
	input wire logic selftestPowerDetectorEnable,
	input wire logic monitorMuxEnable,
	input wire logic [1:0] monitorSelect
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_bw; regWrEn && regAddr == 7'h0C && !initLoad; endsequence
	sequence s_init; initLoad && !fuseValid && regAddr == 7'h0B
		##1 regAddr == 7'h0B && !regWrEn && !initLoad; endsequence
	a_phase_write: assert property (s_bw |=> selftestPhase == $past(regWrData[3:1]))
		else $error("phase field wrong");
	a_mux_write: assert property (s_bw |=> {monitorSelect, monitorMuxEnable} == $past(regWrData[7:5]))
		else $error("monitor fields wrong");
	a_pd_write: assert property (s_bw |=> selftestPowerDetectorEnable == $past(regWrData[4]))
		else $error("detector enable wrong");
	a_init_off: assert property (initLoad |=> !(monitorMuxEnable || selftestPowerDetectorEnable || selftestEnable))
		else $error("self-test not off after init");
	a_init_value: assert property (s_init |=> regRdData == 16'h001B)
		else $error("init value wrong");
	a_rose_hit: assert property ($rose(targetDetect) |-> $past(hitPulse))
		else $error("detect rose without hit");
	a_unmapped_zero: assert property (regAddr > 7'h0C || regAddr < 7'h0B |=> regRdData == 16'h0000)
		else $error("unmapped read not zero");
	a_upper_zero: assert property (regAddr == 7'h0C |=> regRdData[15:8] == 8'h00)
		else $error("upper byte not zero");
endmodule
bind thc_detector thc_sva u_sva (.*);

// ### thc_host.sv
/* host model driving the register port and detector enable; assumes one bench clock */
`timescale 1ns/1ps
module thc_host (
	// clock
	input wire logic clk,
	// register port and enable
	output logic [6:0] regAddr,
	output logic regWrEn,
	output logic [15:0] regWrData,
	input wire logic [15:0] regRdData,
	output logic digitalDetectorEnable
);
	initial begin
		regAddr = 7'h0B;
		regWrEn = 1'b0;
		regWrData = 16'h0000;
		digitalDetectorEnable = 1'b0;
	end
	task automatic en(input logic v);
		@(posedge clk);
		digitalDetectorEnable <= v;
	endtask
	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		if (a == thc_pkg::ADDR_DET_CFG) en(1'b0);
		@(posedge clk);
		regAddr <= a;
		regWrEn <= 1'b1;
		regWrData <= d;
		@(posedge clk);
		regWrEn <= 1'b0;
		regWrData <= ~d;
	endtask
	task automatic rd(input logic [6:0] a, output logic [15:0] d);
		@(posedge clk);
		regAddr <= a;
		@(posedge clk);
		#1;
		d = regRdData;
	endtask
endmodule

// ### thc_tb.sv
/* bench of thc_detector with host model and direction model; assumes TICK_CYCLES 4 */
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin err_count++; \
	$display("wrong value at %0t: %h expected %h", $time, a, e); end end
module tb;
	logic clk, rst, initLoad, fuseValid, hitPulse, hitApproaching, regWrEn, dir;
	logic targetDetect, targetDirection, selftestEnable, selftestPowerDetectorEnable;
	logic monitorMuxEnable, digitalDetectorEnable;
	logic [1:0] monitorSelect, detectionHoldTimeSel;
	logic [2:0] selftestPhase;
	logic [4:0] fuseDetCfg;
	logic [6:0] regAddr;
	logic [15:0] regWrData, regRdData, rv, q;
	int err_count, comparisons, seed, cyc, ca, cb, n, t;
	thc_detector #(.TICK_CYCLES(4)) dut (.*);
	thc_host host (.*);
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc > 6000) begin
			err_count++;
			summarize();
		end
	end
	task automatic summarize;
		$display("%0d comparisons, %0d wrong", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic hits(input int k);
		logic r;
		@(posedge clk);
		repeat (k) begin
			r = 1'($random(seed));
			hitPulse <= 1'b1;
			hitApproaching <= r;
			@(posedge clk);
			if (r) ca++;
			else cb++;
			if (ca == t || cb == t) begin
				ca = 0;
				cb = 0;
				dir = r;
			end
		end
		hitPulse <= 1'b0;
		#1;
	endtask
	task automatic cfg(input logic [15:0] d);
		host.wr(7'h0B, d);
		n = 10 << d[1:0];
		t = d[4] ? n / 2 : n;
		ca = 0;
		cb = 0;
		host.en(1'b1);
	endtask
	initial begin
		seed = 43342;
		{rst, initLoad, fuseValid, hitPulse, hitApproaching, dir} = 6'h20;
		fuseDetCfg = 5'h00;
		detectionHoldTimeSel = 2'h0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		host.rd(7'h05, q); `CHK(q, 16'h0000)
		host.rd(7'h0C, q); `CHK(q, 16'h0000)
		host.rd(7'h0B, q); `CHK(q, 16'h8000)
		for (int f = 0; f < 2; f++) begin
			@(posedge clk);
			fuseValid <= f[0];
			fuseDetCfg <= 5'($random(seed));
			initLoad <= 1'b1;
			@(posedge clk);
			initLoad <= 1'b0;
			host.rd(7'h0B, q); `CHK(q, f ? {11'h000, fuseDetCfg} : 16'h001B)
		end
		$display("register defaults done");
		for (int i = 0; i < 8; i++) begin
			rv = 16'($random(seed));
			rv[3:1] = i[2:0];
			rv[7:6] = i[1:0];
			host.wr(7'h0C, rv);
			#1;
			`CHK(selftestPhase, rv[3:1])
			`CHK({monitorSelect, monitorMuxEnable}, rv[7:5])
			`CHK({selftestPowerDetectorEnable, selftestEnable}, {rv[4], rv[0]})
			host.rd(7'h0C, q); `CHK(q, {8'h00, rv[7:0]})
		end
		$display("self-test control done");
		for (int c = 0; c < 8; c++) begin
			cfg({11'h000, c[2], 2'h3, c[1:0]});
			hits(n - 1); `CHK(targetDetect, 1'b0)
			hits(1); `CHK(targetDetect, 1'b1)
			`CHK(targetDirection, dir)
			repeat (30) @(posedge clk);
			#1;
			`CHK(targetDetect, 1'b1)
			repeat (15) @(posedge clk);
			#1;
			`CHK(targetDetect, 1'b0)
		end
		$display("hit and direction counts done");
		cfg(16'h0000);
		hits(9);
		repeat (30) @(posedge clk);
		hits(1); `CHK(targetDetect, 1'b1)
		repeat (50) @(posedge clk);
		hits(9);
		repeat (60) @(posedge clk);
		hits(1); `CHK(targetDetect, 1'b0)
		$display("target-gone timeout done");
		summarize();
	end
endmodule
